// ### core/qfgas_apb_decode.v
// Purpose: APB address decode for the alarm summary register set
// Assumes: aligned word accesses
// Notes:   one-hot select, miss flags unmapped address
`timescale 1ns/1ns
`include "qfgas_consts.vh"

module qfgas_apb_decode (
   // address
   input  wire [`QFGAS_ADDR_W-1:0] paddr,
   // selects
   output wire                     selSummary,
   output wire                     selMask,
   output wire                     selLinePtr,
   output wire                     selLinkPtr,
   output wire                     selIrqStat,
   output wire                     selIrqMask,
   output wire                     miss
);

   wire [9:0] idx;

   function hit;
      input [9:0] a;
      input [9:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   assign idx        = paddr[`QFGAS_ADDR_W-1:`QFGAS_IDX_LSB];
   assign selSummary = hit(idx, `QFGAS_IDX_SUMMARY);
   assign selMask    = hit(idx, `QFGAS_IDX_GMASK);
   assign selLinePtr = hit(idx, `QFGAS_IDX_LINEPTR);
   assign selLinkPtr = hit(idx, `QFGAS_IDX_LINKPTR);
   assign selIrqStat = hit(idx, `QFGAS_IDX_IRQSTAT);
   assign selIrqMask = hit(idx, `QFGAS_IDX_IRQMASK);
   assign miss       = ~(selSummary | selMask | selLinePtr | selLinkPtr
                         | selIrqStat | selIrqMask) | (paddr[1:0] != 2'h0);

endmodule

// ### core/qfgas_chan_merge.v
// Purpose: OR per-channel latched events into global summary and line pointer; link pointer passes link events through
// Assumes: channel vectors packed channel-major, eight categories each
// Notes:   combinational; registered in the top
`timescale 1ns/1ns
`include "qfgas_consts.vh"

module qfgas_chan_merge #(
   parameter CHANS = 4,
   parameter CATS  = 8
) (
   // per-channel inputs
   input  wire [CHANS*CATS-1:0] chanLatched,
   input  wire [CHANS*CATS-1:0] chanMask,
   input  wire [CHANS-1:0]      chanLinkEvent,
   // merged outputs
   output reg  [CATS-1:0]       summary,
   output reg  [CHANS-1:0]      linePtr,
   output wire [CHANS-1:0]      linkPtr
);

   integer c;
   integer k;
   reg     [CATS-1:0] live;

   always @* begin
      summary = {CATS{1'b0}};
      linePtr = {CHANS{1'b0}};
      live    = {CATS{1'b0}};
      for (c = 0; c < CHANS; c = c + 1) begin
         for (k = 0; k < CATS; k = k + 1) begin
            // unmasked channel events only
            live[k] = chanLatched[c*CATS+k] & ~chanMask[c*CATS+k];
         end
         summary    = summary | live;
         linePtr[c] = |live;
      end
   end

   assign linkPtr = chanLinkEvent;

endmodule

// ### core/qfgas_consts.vh
// Purpose: constants for the quad framer global alarm summary block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   printed offsets are register indices; byte address is four times index
`ifndef QFGAS_CONSTS_VH
`define QFGAS_CONSTS_VH

// --------------------------------------------------------------------------
// register indices
// --------------------------------------------------------------------------
`define QFGAS_IDX_SUMMARY    10'h00a
`define QFGAS_IDX_GMASK      10'h00b
`define QFGAS_IDX_LINEPTR    10'h00c
`define QFGAS_IDX_LINKPTR    10'h00e
`define QFGAS_IDX_IRQSTAT    10'h020
`define QFGAS_IDX_IRQMASK    10'h021

// --------------------------------------------------------------------------
// address layout and fields
// --------------------------------------------------------------------------
`define QFGAS_ADDR_W         12
`define QFGAS_IDX_LSB        2
`define QFGAS_CAT_W          8
`define QFGAS_CHAN_N         4
`define QFGAS_PTR_W          4
`define QFGAS_IRQ_W          3
`define QFGAS_IRQ_SUMMARY    0
`define QFGAS_IRQ_LINE       1
`define QFGAS_IRQ_LINK       2

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define QFGAS_GMASK_RST      8'h00
`define QFGAS_IRQMASK_RST    3'h0

`endif

// ### core/qfgas_top.v
// Purpose: global alarm summary, mask, channel pointers and interrupt
// Assumes: channel latched bits and masks are synchronous to sys_clk
// Notes:   APB slave, no wait states, pslverr on unmapped address

`timescale 1ns/1ns
`include "qfgas_consts.vh"

// Behaviour
// - each summary bit is OR of that category's latched bit over all channels
// - a channel contributes only when its own category mask bit is zero
// - global mask bit one suppresses interrupt for that summary bit
// - summary and pointers read-only; global mask and interrupt mask writable and read back
// - summary bit 7 is any channel loss of signal
// - summary bit 6 is any channel alarm indication signal
// - summary bit 5 is any channel out of frame
// - summary bit 4 is any channel remote alarm
// - summary bit 3 is any channel frame alignment change
// - summary bit 2 is any channel multiframe alignment loss
// - summary bit 1 any transmit slip, bit 0 any receive slip
// - global mask bits follow the same category order as summary
// - each global mask bit gates only that category's summary interrupt, not the summary register
// - two pointer registers name channels with line and link events
// - line pointer bits 3..0 mark channels 4..1 with latched line events
// - link pointer bits 3..0 mark channels 4..1 with latched link events
module qfgas_top #(
   parameter CHANS = `QFGAS_CHAN_N,
   parameter CATS  = `QFGAS_CAT_W
) (
   // clock and reset
   input  wire                     sys_clk,
   input  wire                     rst,
   // apb slave
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [`QFGAS_ADDR_W-1:0] paddr,
   input  wire [31:0]              pwdata,
   output reg  [31:0]              prdata,
   output reg                      pready,
   output reg                      pslverr,
   // per-channel latched events, bit 7 loss of signal .. bit 0 receive slip
   input  wire [CHANS*CATS-1:0]    chanLatched,
   input  wire [CHANS*CATS-1:0]    chanMask,
   input  wire [CHANS-1:0]         chanLinkEvent,
   // alarm outputs
   output reg  [CATS-1:0]          anyAlarm,
   output reg                      irq
);

   // -----------------------------------------------------------------------
   // registers and wires
   // -----------------------------------------------------------------------
   reg  [CATS-1:0]         gMask_r;
   reg  [`QFGAS_IRQ_W-1:0] irqStat_r;
   reg  [`QFGAS_IRQ_W-1:0] irqStat_nxt;
   reg  [`QFGAS_IRQ_W-1:0] irqMask_r;
   reg  [CHANS-1:0]        linePtr_r;
   reg  [CHANS-1:0]        linkPtr_r;
   reg  [31:0]             rdMux;
   wire [CATS-1:0]         summaryNow;
   wire [CHANS-1:0]        linePtrNow;
   wire [CHANS-1:0]        linkPtrNow;
   wire [`QFGAS_IRQ_W-1:0] irqEvent;
   wire                    selSummary;
   wire                    selMask;
   wire                    selLinePtr;
   wire                    selLinkPtr;
   wire                    selIrqStat;
   wire                    selIrqMask;
   wire                    miss;
   wire                    access;
   wire                    wrEn;
   wire                    sumIrq;

   // -----------------------------------------------------------------------
   // channel merge
   // -----------------------------------------------------------------------
   qfgas_chan_merge #(
      .CHANS (CHANS),
      .CATS  (CATS)
   ) u_merge (
      .chanLatched   (chanLatched),
      .chanMask      (chanMask),
      .chanLinkEvent (chanLinkEvent),
      .summary       (summaryNow),
      .linePtr       (linePtrNow),
      .linkPtr       (linkPtrNow)
   );

   // -----------------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------------
   qfgas_apb_decode u_dec (
      .paddr      (paddr),
      .selSummary (selSummary),
      .selMask    (selMask),
      .selLinePtr (selLinePtr),
      .selLinkPtr (selLinkPtr),
      .selIrqStat (selIrqStat),
      .selIrqMask (selIrqMask),
      .miss       (miss)
   );

   assign access = psel & penable & pready;
   assign wrEn   = access & pwrite & ~miss;

   // -----------------------------------------------------------------------
   // summary, pointers, mask
   // -----------------------------------------------------------------------
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         anyAlarm  <= {CATS{1'b0}};
         linePtr_r <= {CHANS{1'b0}};
         linkPtr_r <= {CHANS{1'b0}};
      end else begin
         anyAlarm  <= summaryNow;
         linePtr_r <= linePtrNow;
         linkPtr_r <= linkPtrNow;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gMask_r <= `QFGAS_GMASK_RST;
      end else if (wrEn && selMask) begin
         gMask_r <= pwdata[CATS-1:0];
      end
   end

   // -----------------------------------------------------------------------
   // interrupt status
   // -----------------------------------------------------------------------
   assign sumIrq = |(anyAlarm & ~gMask_r);

   assign irqEvent[`QFGAS_IRQ_SUMMARY] = sumIrq;
   assign irqEvent[`QFGAS_IRQ_LINE]    = |linePtr_r;
   assign irqEvent[`QFGAS_IRQ_LINK]    = |linkPtr_r;

   always @* begin
      irqStat_nxt = irqStat_r;
      if (wrEn && selIrqStat) begin
         irqStat_nxt = irqStat_nxt & ~pwdata[`QFGAS_IRQ_W-1:0];
      end
      // set wins over clear
      irqStat_nxt = irqStat_nxt | irqEvent;
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irqStat_r <= {`QFGAS_IRQ_W{1'b0}};
         irqMask_r <= `QFGAS_IRQMASK_RST;
         irq       <= 1'b0;
      end else begin
         irqStat_r <= irqStat_nxt;
         if (wrEn && selIrqMask) begin
            irqMask_r <= pwdata[`QFGAS_IRQ_W-1:0];
         end
         // level summary also forces irq while live
         irq <= sumIrq | (|(irqStat_r & irqMask_r));
      end
   end

   // -----------------------------------------------------------------------
   // apb read and handshake
   // -----------------------------------------------------------------------
   always @* begin
      rdMux = 32'h0000_0000;
      case (1'b1)
         selSummary: rdMux[CATS-1:0] = anyAlarm;
         selMask:    rdMux[CATS-1:0] = gMask_r;
         selLinePtr: rdMux[CHANS-1:0] = linePtr_r;
         selLinkPtr: rdMux[CHANS-1:0] = linkPtr_r;
         selIrqStat: rdMux[`QFGAS_IRQ_W-1:0] = irqStat_r;
         selIrqMask: rdMux[`QFGAS_IRQ_W-1:0] = irqMask_r;
         default:    rdMux = 32'h0000_0000;
      endcase
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         // answer in the first access cycle after setup
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & miss;
         // unmapped or write setup reads back zero, never a stale word
         if (psel && !penable) begin
            prdata <= (!pwrite && !miss) ? rdMux : 32'h0000_0000;
         end else if (!psel) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule

// ### testbench/qfgas_chan_model.sv
// Purpose: four framer channels holding latched events and masks
// Assumes: new values loaded on a strobe
// Notes:   levels hold until the next load
`timescale 1ns/1ns
module qfgas_chan_model (
   // control
   input  wire        sys_clk,
   input  wire        ld,
   input  wire [31:0] evIn,
   input  wire [31:0] mkIn,
   input  wire [3:0]  lkIn,
   // channel side
   output reg  [31:0] chanLatched,
   output reg  [31:0] chanMask,
   output reg  [3:0]  chanLinkEvent
);
   initial {chanLatched, chanMask, chanLinkEvent} = 68'h0;
   always @(posedge sys_clk) begin
      if (ld) begin
         chanLatched   <= evIn;
         chanMask      <= mkIn;
         chanLinkEvent <= lkIn;
      end
   end
endmodule

// ### testbench/qfgas_top_assertions.sv
// Purpose: port assertions for the alarm summary top
// Assumes: one clock, async active-high reset
// Notes:   bound below to every qfgas_top
`timescale 1ns/1ns
module qfgas_checker #(
   parameter CHANS = 4,
   parameter CATS  = 8
) (
   // clock, reset, apb
   input wire                  sys_clk,
   input wire                  rst,
   input wire                  psel,
   input wire                  penable,
   input wire [11:0]           paddr,
   input wire                  pready,
   input wire                  pslverr,
   // channels and summary
   input wire [CHANS*CATS-1:0] chanLatched,
   input wire [CHANS*CATS-1:0] chanMask,
   input wire [CATS-1:0]       anyAlarm
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [CATS-1:0] sumNow;
   wire             hit = paddr inside {12'h028, 12'h02c, 12'h030, 12'h038, 12'h080, 12'h084};
   always_comb begin
      sumNow = '0;
      for (int c = 0; c < CHANS; c++)
         sumNow |= chanLatched[c*CATS+:CATS] & ~chanMask[c*CATS+:CATS];
   end
   AST_SUM_OR: assert property (1'b1 |=> anyAlarm == $past(sumNow))
      else $error("summary differs from unmasked channel or");
   AST_SUM_HOLD: assert property (($stable(chanLatched) && $stable(chanMask))[*3] |-> $stable(anyAlarm))
      else $error("summary moved with steady inputs");
   AST_SUM_CLR: assert property ((chanLatched == '0)[*2] |-> anyAlarm == '0)
      else $error("summary not cleared");
   AST_RDY_NEXT: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_RDY_PHASE: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   AST_IDLE: assert property (!psel |=> !pready)
      else $error("ready without select");
   AST_ERR_WITH: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_ERR_ADDR: assert property (psel && !penable |=> pslverr == !$past(hit))
      else $error("error flag wrong for address");
endmodule

bind qfgas_top qfgas_checker #(.CHANS(CHANS), .CATS(CATS)) chk (.sys_clk(sys_clk), .rst(rst),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .chanLatched(chanLatched), .chanMask(chanMask), .anyAlarm(anyAlarm));

// ### testbench/quad_framer_global_alarm_summary_test.sv
// Purpose: self-checking bench for the alarm summary top
// Assumes: 20 MHz clock, apb master per transfer
// Notes:   expectations from a behavioural model
`timescale 1ns/1ns
module quad_framer_global_alarm_summary_test;
   reg         sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ld = 0, err;
   reg  [11:0] paddr = 0;
   reg  [31:0] pwdata = 0, evIn = 0, mkIn = 0, rd, seed = 32'heaf56e2f, ev, mk;
   reg  [3:0]  lkIn = 0;
   reg  [7:0]  gm;
   reg  [11:0] s;
   wire [31:0] prdata, chanLatched, chanMask;
   wire [3:0]  chanLinkEvent;
   wire [7:0]  anyAlarm;
   wire        pready, pslverr, irq;
   integer     fails = 0, n_tests = 0, cyc = 0, i;

   qfgas_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chanLatched(chanLatched), .chanMask(chanMask),
      .chanLinkEvent(chanLinkEvent), .anyAlarm(anyAlarm), .irq(irq));
   qfgas_chan_model far (.sys_clk(sys_clk), .ld(ld), .evIn(evIn), .mkIn(mkIn),
      .lkIn(lkIn), .chanLatched(chanLatched), .chanMask(chanMask),
      .chanLinkEvent(chanLinkEvent));

   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         final_report;
      end
   end

   // ------------------------------------------------------------
   // model and tasks
   // ------------------------------------------------------------
   function [31:0] xs(input [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   function [11:0] sp(input [31:0] l, input [31:0] m);
      integer c;
      sp = 12'h0;
      for (c = 0; c < 4; c = c + 1) begin
         sp[7:0] = sp[7:0] | (l[c*8+:8] & ~m[c*8+:8]);
         sp[8+c] = |(l[c*8+:8] & ~m[c*8+:8]);
      end
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rdc(input [11:0] a, input [31:0] exp);
      apb(a, 0, 0);
      chk(rd, exp);
      chk(err, 0);
   endtask
   task setIn(input [31:0] l, input [31:0] m, input [3:0] k);
      @(posedge sys_clk);
      ld <= 1;
      evIn <= l;
      mkIn <= m;
      lkIn <= k;
      @(posedge sys_clk);
      ld <= 0;
      repeat (4) @(posedge sys_clk);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 0;
      rdc(12'h028, 0);
      rdc(12'h02c, 0);
      for (i = 0; i < 8; i = i + 1) begin
         setIn(32'h1 << (i + 8 * (i % 4)), 0, 0);
         chk(anyAlarm, 8'h1 << i);
      end
      for (i = 0; i < 24; i = i + 1) begin
         seed = xs(seed);
         ev = seed;
         seed = xs(seed);
         mk = seed & (seed >> 9);
         gm = seed[19:12];
         apb(12'h02c, 1, {24'h0, gm});
         setIn(ev, mk, seed[3:0]);
         s = sp(ev, mk);
         chk(anyAlarm, s[7:0]);
         chk(irq, |(s[7:0] & ~gm));
         apb(12'h028, 1, 32'hffffffff);
         apb(12'h030, 1, 32'hffffffff);
         rdc(12'h028, s[7:0]);
         rdc(12'h02c, gm);
         rdc(12'h030, s[11:8]);
         rdc(12'h038, seed[3:0]);
      end
      apb(12'h040, 0, 0);
      chk(rd, 0);
      chk(err, 1);
      apb(12'h029, 0, 0);
      chk(rd, 0);
      chk(err, 1);
      apb(12'h02c, 1, 32'hff);
      setIn(32'h01010101, 0, 0);
      chk(irq, 0);
      setIn(0, 0, 0);
      apb(12'h080, 1, 7);
      setIn(0, 0, 1);
      rdc(12'h080, 4);
      chk(irq, 0);
      apb(12'h084, 1, 4);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1);
      setIn(0, 0, 0);
      chk(irq, 1);
      apb(12'h080, 1, 4);
      repeat (2) @(posedge sys_clk);
      chk(irq, 0);
      // mid-run reset returns mask registers to zero
      @(posedge sys_clk);
      rst <= 1;
      repeat (2) @(posedge sys_clk);
      rst <= 0;
      chk(irq, 0);
      chk(anyAlarm, 0);
      rdc(12'h02c, 0);
      rdc(12'h084, 0);
      final_report;
   end
endmodule
